// file: logic/pmbus_bank_regs.vh
// Summary of operation
// - Status word low byte: summary fault bits
// - Status word high byte: group fault bits
// - Unsupported status bits read zero, reset zero
// - Output voltage status: only overvoltage bit 7
// - Output current status: fault 7, warning 5
// - Input status: OV 7, UV 4, off 3
// - Temperature status: fault 7, warning 6
// - Comms status: command 7, data 6, check 5
// - Operation: on/off and margins, fixed read-only bits
// - Soft-off and ignore-fault margins never take effect
// - Margin field: 00XX off, 0110 low, 1010 high
// - On/off config: polarity strap, only bit 2 writable
// - Store all to non-volatile within 500 ms
// - Restore all from non-volatile within 200 ms
// - Output voltage format reads fixed 0x14
// - Format byte: mode in [7:5], exponent [4:0]
// - Set points: 16-bit mantissa, exponent -12
`ifndef PMBUS_BANK_REGS_VH
`define PMBUS_BANK_REGS_VH
////////////////////////////////////////////////////////////////////////////////
// Command codes
`define CMD_OPERATION      8'h01
`define CMD_ON_OFF_CONFIG  8'h02
`define CMD_CLEAR_FAULTS   8'h03
`define CMD_STORE_ALL      8'h11
`define CMD_RESTORE_ALL    8'h12
`define CMD_VOUT_FORMAT    8'h20
`define CMD_STATUS_WORD    8'h79
`define CMD_OUTPUT_VOLTAGE_STATUS    8'h7a
`define CMD_OUTPUT_CURRENT_STATUS    8'h7b
`define CMD_STATUS_INPUT   8'h7c
`define CMD_STATUS_TEMP    8'h7d
`define CMD_STATUS_COMM    8'h7e
////////////////////////////////////////////////////////////////////////////////
// Reset values and fixed fields
`define OPERATION_RST      8'h88
`define OPERATION_WR_MASK  8'hb0
`define ON_OFF_RST_FIXED   8'h1d
`define ON_OFF_WR_BIT      2
`define ON_OFF_POL_BIT     1
`define OUTPUT_VOLTAGE_FORMAT_SEL      3'h0
`define VOUT_EXPONENT      5'h14
`define SLAVE_ADDR_RST     7'h40
`define PEC_POLY           8'h07
////////////////////////////////////////////////////////////////////////////////
// Field positions
`define OP_ON_BIT          7
`define OP_MARGIN_HI       5
`define OP_MARGIN_LO       4
`define ST_VOUT_OV         7
`define ST_IOUT_OC         7
`define ST_IOUT_WARN       5
`define ST_IN_OV           7
`define ST_IN_UV           4
`define ST_IN_LOW_OFF      3
`define ST_OT_FAULT        7
`define ST_OT_WARN         6
`define ST_CML_CMD         7
`define ST_CML_DATA        6
`define ST_CML_PEC         5
`define SW_VOUT            15
`define SW_IOUT            14
`define SW_INPUT           13
`define SW_PG_N            11
`define SW_OFF             6
`define SW_OV              5
`define SW_OC              4
`define SW_UV              3
`define SW_TEMP            2
`define SW_CML             1
////////////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_KHZ            25000
`define STORE_MS           500
`define RESTORE_MS         200
`define STORE_CYCLES       (`STORE_MS * `CLK_KHZ)
`define RESTORE_CYCLES     (`RESTORE_MS * `CLK_KHZ)
`endif

// file: logic/param_store_mem.v
`timescale 1ns/1ps
`default_nettype none
// Small non-volatile image of the writable parameters; read data registered
module param_store_mem (
	input  wire        i_clk,
	input  wire        i_we,
	input  wire [1:0]  i_addr,
	input  wire [15:0] i_wdata,
	output reg  [15:0] o_rdata
);
	reg [15:0] mem [0:3];

	// Write port and registered read port
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule // param_store_mem
`default_nettype wire

// file: logic/serial_byte_link.v
`timescale 1ns/1ps
`default_nettype none
// Two-wire slave: clock and data sampled by i_clk, byte-level events out
module serial_byte_link (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire [6:0] i_addr,
	input  wire       i_scl,
	input  wire       i_sda,
	output wire       o_sda,
	output wire       o_sda_oe_n,
	input  wire [7:0] i_tx_byte,
	output reg        o_addr_hit,
	output reg        o_read,
	output reg        o_rx_valid,
	output reg  [7:0] o_rx_byte,
	output reg        o_tx_req,
	output reg        o_stop
);
	localparam L_IDLE = 3'h0;
	localparam L_ADDR = 3'h1;
	localparam L_RX   = 3'h2;
	localparam L_ACK  = 3'h3;
	localparam L_TX   = 3'h4;
	localparam L_MACK = 3'h5;

	reg [2:0] scl_s_r;
	reg [2:0] sda_s_r;
	reg [2:0] state_r;
	reg [3:0] cnt_r;
	reg [7:0] sh_r;
	reg       pull_r;
	wire      scl_rise = scl_s_r[1] & ~scl_s_r[2];
	wire      scl_fall = ~scl_s_r[1] & scl_s_r[2];
	wire      start    = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
	wire      stop     = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];

	// Open drain: only ever pull low
	assign o_sda      = 1'b0;
	assign o_sda_oe_n = ~pull_r;

	// Two-stage synchronisers, third stage for edge finding
	always @(posedge i_clk) begin
		if (i_rst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
		end else begin
			scl_s_r <= {scl_s_r[1:0], i_scl};
			sda_s_r <= {sda_s_r[1:0], i_sda};
		end
	end

	// Bit engine
	always @(posedge i_clk) begin
		o_addr_hit <= 1'b0;
		o_rx_valid <= 1'b0;
		o_tx_req   <= 1'b0;
		o_stop     <= 1'b0;
		if (i_rst) begin
			state_r   <= L_IDLE;
			cnt_r     <= 4'h0;
			sh_r      <= 8'h00;
			pull_r    <= 1'b0;
			o_read    <= 1'b0;
			o_rx_byte <= 8'h00;
		end else if (stop) begin
			state_r <= L_IDLE;
			pull_r  <= 1'b0;
			o_stop  <= 1'b1;
		end else if (start) begin
			state_r <= L_ADDR;
			cnt_r   <= 4'h0;
			pull_r  <= 1'b0;
		end else begin
			case (state_r)
			L_ADDR, L_RX: begin
				if (scl_rise) begin
					sh_r  <= {sh_r[6:0], sda_s_r[1]};
					cnt_r <= cnt_r + 4'h1;
				end else if (scl_fall && cnt_r == 4'h8) begin
					if (state_r == L_RX) begin
						o_rx_valid <= 1'b1;
						o_rx_byte  <= sh_r;
						pull_r     <= 1'b1;
						state_r    <= L_ACK;
					end else if (sh_r[7:1] == i_addr) begin
						o_addr_hit <= 1'b1;
						o_rx_byte  <= sh_r;
						o_read     <= sh_r[0];
						o_tx_req   <= sh_r[0];
						pull_r     <= 1'b1;
						state_r    <= L_ACK;
					end else begin
						state_r <= L_IDLE;
					end
				end
			end
			L_ACK: begin
				if (scl_fall) begin
					cnt_r <= o_read ? 4'h1 : 4'h0;
					if (o_read) begin
						pull_r  <= ~i_tx_byte[7];
						sh_r    <= {i_tx_byte[6:0], 1'b1};
						state_r <= L_TX;
					end else begin
						pull_r  <= 1'b0;
						state_r <= L_RX;
					end
				end
			end
			L_TX: begin
				if (scl_fall) begin
					if (cnt_r == 4'h8) begin
						pull_r  <= 1'b0;
						state_r <= L_MACK;
					end else begin
						pull_r <= ~sh_r[7];
						sh_r   <= {sh_r[6:0], 1'b1};
						cnt_r  <= cnt_r + 4'h1;
					end
				end
			end
			L_MACK: begin
				if (scl_rise) begin
					o_tx_req <= ~sda_s_r[1];
					state_r  <= sda_s_r[1] ? L_IDLE : L_ACK;
				end
			end
			default: begin
				state_r <= L_IDLE;
				pull_r  <= 1'b0;
			end
			endcase
		end
	end
endmodule // serial_byte_link
`default_nettype wire

// file: logic/pmbus_status_command_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "pmbus_bank_regs.vh"
module pmbus_status_command_bank #(
	parameter [31:0] STORE_CYC   = `STORE_CYCLES,
	parameter [31:0] RESTORE_CYC = `RESTORE_CYCLES
) (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_scl,
	input  wire        i_sda,
	output wire        o_sda,
	output wire        o_sda_oe_n,
	input  wire        i_onoff_polarity,
	input  wire        i_vout_ov,
	input  wire        i_iout_oc,
	input  wire        i_iout_oc_warn,
	input  wire        i_vin_ov,
	input  wire        i_vin_uv,
	input  wire        i_vin_low_off,
	input  wire        i_ot_fault,
	input  wire        i_ot_warn,
	input  wire        i_power_good,
	input  wire        i_shutdown,
	output reg         o_output_on,
	output reg  [1:0]  o_margin,
	output reg  [7:0]  o_on_off_config,
	output reg         o_busy
);
	localparam [1:0] MARGIN_OFF  = 2'h0;
	localparam [1:0] MARGIN_LOW  = 2'h1;
	localparam [1:0] MARGIN_HIGH = 2'h2;
	localparam [1:0] JOB_NONE    = 2'h0;
	localparam [1:0] JOB_STORE   = 2'h1;
	localparam [1:0] JOB_RESTORE = 2'h2;
	localparam [7:0] ON_OFF_DEF  = `ON_OFF_RST_FIXED;

	// CRC-8 step for packet error checking
	function [7:0] crc8;
		input [7:0] crc;
		input [7:0] din;
		integer k;
		reg [7:0] c;
		begin
			c = crc ^ din;
			for (k = 0; k < 8; k = k + 1) begin
				c = c[7] ? ({c[6:0], 1'b0} ^ `PEC_POLY) : {c[6:0], 1'b0};
			end
			crc8 = c;
		end
	endfunction

	// Expected data byte count for a write, 2'h3 when not writable
	function [1:0] wr_len;
		input [7:0] cmd;
		begin
			case (cmd)
			`CMD_OPERATION, `CMD_ON_OFF_CONFIG: wr_len = 2'h1;
			`CMD_CLEAR_FAULTS, `CMD_STORE_ALL, `CMD_RESTORE_ALL: wr_len = 2'h0;
			default: wr_len = 2'h3;
			endcase
		end
	endfunction

	// Codes that answer a read; anything else is an unsupported command
	function rd_known;
		input [7:0] cmd;
		begin
			case (cmd)
			`CMD_OPERATION, `CMD_ON_OFF_CONFIG, `CMD_VOUT_FORMAT, `CMD_STATUS_WORD,
			`CMD_OUTPUT_VOLTAGE_STATUS, `CMD_OUTPUT_CURRENT_STATUS, `CMD_STATUS_INPUT, `CMD_STATUS_TEMP,
			`CMD_STATUS_COMM: rd_known = 1'b1;
			default: rd_known = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Link and parameter memory
	wire        addr_hit;
	wire        rd_phase;
	wire        rx_valid;
	wire [7:0]  rx_byte;
	wire        tx_req;
	wire        stop;
	wire [15:0] nv_rdata;
	reg  [7:0]  tx_byte_r;
	reg         nv_we_r;
	reg  [7:0]  op_r;

	serial_byte_link i_serial_byte_link (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_addr     (`SLAVE_ADDR_RST),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda      (o_sda),
		.o_sda_oe_n (o_sda_oe_n),
		.i_tx_byte  (tx_byte_r),
		.o_addr_hit (addr_hit),
		.o_read     (rd_phase),
		.o_rx_valid (rx_valid),
		.o_rx_byte  (rx_byte),
		.o_tx_req   (tx_req),
		.o_stop     (stop)
	);

	param_store_mem i_param_store_mem (
		.i_clk   (i_clk),
		.i_we    (nv_we_r),
		.i_addr  (2'h0),
		.i_wdata ({o_on_off_config, op_r}),
		.o_rdata (nv_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Polarity strap: synchronised, caught once after reset release
	reg [1:0] pol_s_r;
	reg       pol_done_r;
	reg       pol_r;

	always @(posedge i_clk) begin
		pol_s_r <= {pol_s_r[0], i_onoff_polarity};
		if (i_rst) begin
			pol_done_r <= 1'b0;
			pol_r      <= 1'b0;
		end else if (!pol_done_r) begin
			pol_done_r <= 1'b1;
			pol_r      <= pol_s_r[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transaction tracking
	reg [7:0] cmd_r;
	reg [2:0] nrx_r;
	reg [7:0] d0_r;
	reg [7:0] last_r;
	reg [7:0] crc_r;
	reg [7:0] crc_prev_r;
	reg       got_read_r;
	reg       rd_idx_r;

	// Count bytes, keep command, first data byte and running PEC
	always @(posedge i_clk) begin
		if (i_rst) begin
			cmd_r      <= 8'h00;
			nrx_r      <= 3'h0;
			d0_r       <= 8'h00;
			last_r     <= 8'h00;
			crc_r      <= 8'h00;
			crc_prev_r <= 8'h00;
			got_read_r <= 1'b0;
		end else if (addr_hit && !rd_phase) begin
			nrx_r      <= 3'h0;
			got_read_r <= 1'b0;
			crc_r      <= crc8(8'h00, rx_byte);
		end else if (addr_hit) begin
			got_read_r <= 1'b1;
		end else if (stop) begin
			nrx_r <= 3'h0; // A later stray stop must not run this command again
		end else if (rx_valid) begin
			if (nrx_r == 3'h0) begin
				cmd_r <= rx_byte;
			end
			if (nrx_r == 3'h1) begin
				d0_r <= rx_byte;
			end
			if (nrx_r != 3'h7) begin
				nrx_r <= nrx_r + 3'h1;
			end
			last_r     <= rx_byte;
			crc_prev_r <= crc_r;
			crc_r      <= crc8(crc_r, rx_byte);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers, status flags, store/restore timer
	reg  [7:0]  st_vout_r;
	reg  [7:0]  st_iout_r;
	reg  [7:0]  st_in_r;
	reg  [7:0]  st_temp_r;
	reg  [7:0]  st_cml_r;
	reg  [1:0]  job_r;
	reg  [31:0] tmr_r;
	reg         nv_ok_r;
	reg  [7:0]  cml_set;
	reg         do_clear;
	wire [1:0]  want  = wr_len(cmd_r);
	wire        execw = stop && !got_read_r && nrx_r != 3'h0;
	wire        n_ok  = {1'b0, nrx_r} == {2'h0, want} + 4'h1;
	wire        n_pec = {1'b0, nrx_r} == {2'h0, want} + 4'h2;
	wire        go    = execw && want != 2'h3 && (n_ok || (n_pec && last_r == crc_prev_r));
	wire [1:0]  mfld  = d0_r[`OP_MARGIN_HI:`OP_MARGIN_LO];

	// Classify finished writes and illegal reads into comms flags
	always @* begin
		cml_set  = 8'h00;
		do_clear = go && cmd_r == `CMD_CLEAR_FAULTS;
		if (execw) begin
			if (want == 2'h3 && !(nrx_r == 3'h1 && cmd_r == `CMD_VOUT_FORMAT)) begin
				cml_set[`ST_CML_CMD] = 1'b1;
			end else if (want != 2'h3 && n_pec && last_r != crc_prev_r) begin
				cml_set[`ST_CML_PEC] = 1'b1;
			end else if (!go || (cmd_r == `CMD_OPERATION && mfld == 2'h3)) begin
				cml_set[`ST_CML_DATA] = 1'b1;
			end
		end
		if (tx_req && !rd_idx_r && !rd_known(cmd_r)) begin
			cml_set[`ST_CML_CMD] = 1'b1;
		end
	end

	// Sticky status: hardware set wins over clear
	always @(posedge i_clk) begin
		if (i_rst) begin
			st_vout_r <= 8'h00;
			st_iout_r <= 8'h00;
			st_in_r   <= 8'h00;
			st_temp_r <= 8'h00;
			st_cml_r  <= 8'h00;
		end else begin
			st_vout_r <= (do_clear ? 8'h00 : st_vout_r) | {i_vout_ov, 7'h00};
			st_iout_r <= (do_clear ? 8'h00 : st_iout_r)
				| {i_iout_oc, 1'b0, i_iout_oc_warn, 5'h00};
			st_in_r   <= (do_clear ? 8'h00 : st_in_r)
				| {i_vin_ov, 2'h0, i_vin_uv, i_vin_low_off, 3'h0};
			st_temp_r <= (do_clear ? 8'h00 : st_temp_r)
				| {i_ot_fault, i_ot_warn, 6'h00};
			st_cml_r  <= (do_clear ? 8'h00 : st_cml_r) | cml_set;
		end
	end

	// Operation, on/off configuration, non-volatile jobs
	always @(posedge i_clk) begin
		nv_we_r <= 1'b0;
		if (i_rst) begin
			op_r            <= `OPERATION_RST;
			o_on_off_config <= `ON_OFF_RST_FIXED;
			job_r           <= JOB_NONE;
			tmr_r           <= 32'h0;
			nv_ok_r         <= 1'b0;
		end else begin
			o_on_off_config[`ON_OFF_POL_BIT] <= pol_r;
			if (go && cmd_r == `CMD_OPERATION && mfld != 2'h3) begin
				op_r <= (`OPERATION_RST & ~`OPERATION_WR_MASK)
					| (d0_r & `OPERATION_WR_MASK);
			end
			if (go && cmd_r == `CMD_ON_OFF_CONFIG) begin
				o_on_off_config[`ON_OFF_WR_BIT] <= d0_r[`ON_OFF_WR_BIT];
			end
			if (job_r != JOB_NONE) begin
				tmr_r <= tmr_r - 32'h1;
				if (tmr_r == 32'h1) begin
					job_r <= JOB_NONE;
					if (job_r == JOB_RESTORE) begin
						op_r <= nv_ok_r ? nv_rdata[7:0] : `OPERATION_RST;
						o_on_off_config[`ON_OFF_WR_BIT] <= nv_ok_r
							? nv_rdata[8 + `ON_OFF_WR_BIT] : ON_OFF_DEF[`ON_OFF_WR_BIT];
					end
				end
			end else if (go && cmd_r == `CMD_STORE_ALL) begin
				nv_we_r <= 1'b1;
				nv_ok_r <= 1'b1;
				job_r   <= JOB_STORE;
				tmr_r   <= STORE_CYC;
			end else if (go && cmd_r == `CMD_RESTORE_ALL) begin
				job_r <= JOB_RESTORE;
				tmr_r <= RESTORE_CYC;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path
	wire [15:0] status_word;
	assign status_word = {
		|st_vout_r, |st_iout_r, |st_in_r, 1'b0,
		~i_power_good, 3'h0,
		1'b0, ~op_r[`OP_ON_BIT] | i_shutdown,
		st_vout_r[`ST_VOUT_OV], st_iout_r[`ST_IOUT_OC], st_in_r[`ST_IN_UV],
		|st_temp_r, |st_cml_r, 1'b0
	};

	// Load the next byte of the answer on each link request
	always @(posedge i_clk) begin
		if (i_rst) begin
			tx_byte_r <= 8'hff;
			rd_idx_r  <= 1'b0;
		end else if (tx_req) begin
			rd_idx_r <= 1'b1;
			case (cmd_r)
			`CMD_OPERATION:     tx_byte_r <= op_r;
			`CMD_ON_OFF_CONFIG: tx_byte_r <= o_on_off_config;
			`CMD_VOUT_FORMAT:   tx_byte_r <= {`OUTPUT_VOLTAGE_FORMAT_SEL, `VOUT_EXPONENT};
			`CMD_STATUS_WORD:   tx_byte_r <= rd_idx_r ? status_word[15:8] : status_word[7:0];
			`CMD_OUTPUT_VOLTAGE_STATUS:   tx_byte_r <= st_vout_r;
			`CMD_OUTPUT_CURRENT_STATUS:   tx_byte_r <= st_iout_r;
			`CMD_STATUS_INPUT:  tx_byte_r <= st_in_r;
			`CMD_STATUS_TEMP:   tx_byte_r <= st_temp_r;
			`CMD_STATUS_COMM:   tx_byte_r <= st_cml_r;
			default:            tx_byte_r <= 8'hff;
			endcase
		end else if (addr_hit) begin
			rd_idx_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power stage controls
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_output_on <= 1'b0;
			o_margin    <= MARGIN_OFF;
			o_busy      <= 1'b0;
		end else begin
			o_output_on <= op_r[`OP_ON_BIT];
			o_busy      <= job_r != JOB_NONE;
			case (op_r[5:2])
			4'h6:    o_margin <= MARGIN_LOW;
			4'ha:    o_margin <= MARGIN_HIGH;
			default: o_margin <= MARGIN_OFF;
			endcase
		end
	end
endmodule // pmbus_status_command_bank
`default_nettype wire

// file: sim/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Link master: each clock phase lasts four system cycles, 320 ns a bit
module pmbus_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda_wire,
	output var  logic o_scl,
	output var  logic o_sda_low
);
	// Bus idles high, clock stands still between frames
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Data moves only while the clock is low; sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda_low <= !b;
		q(2);
		o_scl <= 1'b1;
		q(2);
		r = i_sda_wire;
		q(2);
		o_scl <= 1'b0;
		q(2);
	endtask
	task automatic start();
		o_sda_low <= 1'b0;
		q(2);
		o_scl <= 1'b1;
		q(4);
		o_sda_low <= 1'b1;
		q(4);
		o_scl <= 1'b0;
		q(2);
	endtask
	task automatic stop();
		o_sda_low <= 1'b1;
		q(2);
		o_scl <= 1'b1;
		q(4);
		o_sda_low <= 1'b0;
		q(8);
	endtask
	// Eight bits msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(last, nak);
	endtask
	task automatic wr(input logic [7:0] b[$], output logic nak);
		logic [7:0] r;
		logic n;
		nak = 1'b0;
		start();
		foreach (b[i]) begin
			xfer(b[i], 1'b1, r, n);
			nak = nak | n;
		end
		stop();
	endtask
	// Command, repeated start, then n bytes low first; last one not acknowledged
	task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v);
		logic [7:0] r;
		logic k;
		v = 16'h0000;
		start();
		xfer(8'h80, 1'b1, r, k);
		xfer(c, 1'b1, r, k);
		start();
		xfer(8'h81, 1'b1, r, k);
		for (int i = 0; i < n; i++) begin
			xfer(8'hff, i == n - 1, r, k);
			v[8*i +: 8] = r;
		end
		stop();
	endtask
endmodule // pmbus_host_model
`default_nettype wire

// file: sim/pmbus_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks of the command bank
module pmbus_bank_assertions #(
	parameter [31:0] STORE_CYC   = 32'd20,
	parameter [31:0] RESTORE_CYC = 32'd20
) (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_scl,
	input wire logic       i_onoff_polarity,
	input wire logic       o_sda_oe_n,
	input wire logic       o_output_on,
	input wire logic [1:0] o_margin,
	input wire logic [7:0] o_on_off_config,
	input wire logic       o_busy
);
	logic [31:0] busy_cnt_r;
	// Length of the current busy span
	always @(posedge i_clk) begin
		if (i_rst || !o_busy) busy_cnt_r <= 32'h0;
		else busy_cnt_r <= busy_cnt_r + 32'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_reset_vals: assert property ($fell(i_rst) |-> o_margin == 2'h0 && !o_busy &&
		o_sda_oe_n && (o_on_off_config & 8'hfd) == 8'h1d) else $error("bad reset values");
	a_cfg_fixed: assert property ((o_on_off_config & 8'hf9) == 8'h19)
		else $error("config fixed bits wrong");
	a_cfg_strap: assert property (!$past(i_rst) && !$past(i_rst, 2) |->
		o_on_off_config[1] == i_onoff_polarity) else $error("polarity bit wrong");
	a_margin_code: assert property (o_margin != 2'h3) else $error("illegal margin");
	a_on_release: assert property ($fell(i_rst) |-> ##[0:2] o_output_on)
		else $error("output not on after reset");
	a_ctrl_at_stop: assert property ($changed(o_output_on) || $changed(o_margin) |-> i_scl)
		else $error("control changed inside a frame");
	a_busy_bound: assert property (o_busy |-> busy_cnt_r <= STORE_CYC + 32'd8)
		else $error("busy too long");
	a_busy_start: assert property ($rose(o_busy) |-> i_scl ##1 o_busy [*4])
		else $error("busy start wrong");
	c_busy: cover property ($rose(o_busy));
	c_low: cover property (o_margin == 2'h1);
	c_high: cover property (o_margin == 2'h2);
	c_off: cover property ($fell(o_output_on));
endmodule // pmbus_bank_assertions
`default_nettype wire

// file: sim/pmbus_status_command_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_command_bank_test;
	localparam [31:0] CYC = 32'd20;
	localparam logic [7:0] F_CMD [8] = '{8'h7a, 8'h7b, 8'h7b, 8'h7c, 8'h7c, 8'h7c, 8'h7d, 8'h7d};
	localparam logic [7:0] F_BIT [8] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h10, 8'h08, 8'h80, 8'h40};
	localparam logic [15:0] F_WRD [8] = '{16'h8020, 16'h4010, 16'h4000, 16'h2000, 16'h2008,
		16'h2000, 16'h0004, 16'h0004};
	localparam logic [7:0] OP_W [3] = '{8'h98, 8'ha8, 8'hc7};
	localparam logic [7:0] OP_R [3] = '{8'h98, 8'ha8, 8'h88};
	logic       clk;
	logic       rst;
	logic       scl;
	logic       host_low;
	logic       sda_wire;
	logic       sda_oe_n;
	logic       sda_out;
	logic [7:0] flt;
	logic       pg;
	logic       shut;
	logic       pol;
	logic       out_on;
	logic [1:0] margin;
	logic [7:0] cfg;
	logic       busy;
	logic       nak;
	int         num_errors;
	int         cmp_count;
	// Open-drain data line with pull-up
	assign sda_wire = ((!sda_oe_n && !sda_out) || host_low) ? 1'b0 : 1'b1;
	pmbus_status_command_bank #(.STORE_CYC(CYC), .RESTORE_CYC(CYC)) i_pmbus_status_command_bank (
		.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_wire), .o_sda(sda_out),
		.o_sda_oe_n(sda_oe_n), .i_onoff_polarity(pol), .i_vout_ov(flt[0]), .i_iout_oc(flt[1]),
		.i_iout_oc_warn(flt[2]), .i_vin_ov(flt[3]), .i_vin_uv(flt[4]), .i_vin_low_off(flt[5]),
		.i_ot_fault(flt[6]), .i_ot_warn(flt[7]), .i_power_good(pg), .i_shutdown(shut),
		.o_output_on(out_on), .o_margin(margin), .o_on_off_config(cfg), .o_busy(busy));
	pmbus_host_model i_pmbus_host_model (.i_clk(clk), .i_sda_wire(sda_wire), .o_scl(scl),
		.o_sda_low(host_low));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] c, input int n, input logic [15:0] exp);
		logic [15:0] v;
		i_pmbus_host_model.rd(c, n, v);
		cmp(v, exp);
	endtask
	task automatic wr(input logic [7:0] b[$]);
		i_pmbus_host_model.wr(b, nak);
		repeat (4) @(posedge clk);
	endtask
	// Host holds off while the store or restore runs, bounded wait
	task automatic settle();
		int k;
		k = 0;
		while (busy === 1'b1 && k < CYC + 20) begin
			@(posedge clk);
			k++;
		end
		cmp({15'h0, busy}, 16'h0000);
	endtask
	task automatic close_out();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		flt = 8'h00;
		pg = 1'b1;
		shut = 1'b0;
		pol = 1'b1;
		num_errors = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		rd(8'h01, 1, 16'h0088);
		rd(8'h02, 1, 16'h001f);
		rd(8'h20, 1, 16'h0014);
		rd(8'h79, 2, 16'h0000);
		// One-cycle fault pulses latch until cleared
		for (int i = 0; i < 8; i++) begin
			flt <= 8'h01 << i;
			@(posedge clk);
			flt <= 8'h00;
			rd(F_CMD[i], 1, {8'h00, F_BIT[i]});
			rd(8'h79, 2, F_WRD[i]);
			wr({8'h80, 8'h03});
			rd(F_CMD[i], 1, 16'h0000);
		end
		pg <= 1'b0;
		shut <= 1'b1;
		rd(8'h79, 2, 16'h0840);
		pg <= 1'b1;
		shut <= 1'b0;
		// Comms flags accumulate: unknown read, refused margin, bad check byte
		rd(8'h55, 1, 16'h00ff);
		rd(8'h7e, 1, 16'h0080);
		wr({8'h80, 8'h01, 8'hb8});
		rd(8'h7e, 1, 16'h00c0);
		rd(8'h01, 1, 16'h0088);
		wr({8'h80, 8'h01, 8'h00, 8'h00});
		rd(8'h7e, 1, 16'h00e0);
		rd(8'h79, 2, 16'h0002);
		wr({8'h80, 8'h03});
		wr({8'h80, 8'h20, 8'h00});
		rd(8'h7e, 1, 16'h0080);
		rd(8'h20, 1, 16'h0014);
		wr({8'h80, 8'h03});
		i_pmbus_host_model.wr({8'h82, 8'h01, 8'h00}, nak);
		cmp({15'h0, nak}, 16'h0001);
		wr({8'h80, 8'h01, 8'h00});
		cmp({15'h0, out_on}, 16'h0000);
		rd(8'h01, 1, 16'h0008);
		rd(8'h79, 2, 16'h0040);
		wr({8'h80, 8'h01, 8'h80, 8'h97});
		cmp({15'h0, out_on}, 16'h0001);
		for (int i = 0; i < 3; i++) begin
			wr({8'h80, 8'h01, OP_W[i]});
			rd(8'h01, 1, {8'h00, OP_R[i]});
			cmp({14'h0, margin}, (i + 1) % 3);
		end
		wr({8'h80, 8'h02, 8'h00});
		rd(8'h02, 1, 16'h001b);
		cmp({8'h00, cfg}, 16'h001b);
		wr({8'h80, 8'h02, 8'hff});
		rd(8'h02, 1, 16'h001f);
		// Store a margin setting, overwrite it, then bring it back
		wr({8'h80, 8'h01, 8'h98});
		wr({8'h80, 8'h11});
		cmp({15'h0, busy}, 16'h0001);
		settle();
		wr({8'h80, 8'h01, 8'h88});
		cmp({14'h0, margin}, 16'h0000);
		wr({8'h80, 8'h12});
		settle();
		rd(8'h01, 1, 16'h0098);
		cmp({14'h0, margin}, 16'h0001);
		// Mid-run reset with the other strap: defaults return, flags cleared
		wr({8'h80, 8'h20, 8'h00});
		pol <= 1'b0;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		rd(8'h02, 1, 16'h001d);
		rd(8'h01, 1, 16'h0088);
		rd(8'h7e, 1, 16'h0000);
		cmp({14'h0, margin}, 16'h0000);
		cmp({15'h0, out_on}, 16'h0001);
		close_out();
	end
endmodule // pmbus_status_command_bank_test
bind pmbus_status_command_bank pmbus_bank_assertions #(.STORE_CYC(STORE_CYC),
	.RESTORE_CYC(RESTORE_CYC)) i_pmbus_bank_assertions (.i_clk(i_clk), .i_rst(i_rst),
	.i_scl(i_scl), .i_onoff_polarity(i_onoff_polarity), .o_sda_oe_n(o_sda_oe_n),
	.o_output_on(o_output_on), .o_margin(o_margin), .o_on_off_config(o_on_off_config),
	.o_busy(o_busy));
`default_nettype wire
